/* fses_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module fses_ctrl
  import fses_pkg::*;
#(
  parameter int unsigned SPACING = SPACING_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // User request
  input  wire logic              req_valid,
  input  wire fses_req_t         req,
  input  wire logic              byte_mode,
  output logic                   req_ready,
  // User answer
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   window_open,
  output logic                   spacing_late,
  // Flash pins
  output fses_pins_t             pins,
  input  wire logic [DATA_W-1:0] dq_i
);

  // Host budget must close before the device's own window does
  if (SPACING == 0 ||
      SPACING >= WINDOW_US * (CLK_HZ / 1_000_000)) begin : g_spacing_chk
    $error("SPACING must be 1..1249 cycles, under the 50 us window");
  end

  typedef struct packed {
    fses_st_t          st;
    logic [2:0]        idx;
    logic [2:0]        len;
    logic [3:0]        ph;
    logic              rd;
    fses_req_t         cur;
    logic              bmode;
    fses_pins_t        pins;
    logic              rsp_v;
    logic [15:0]       rsp_d;
    logic [15:0]       gap;
    logic              win;
    logic              late;
    logic [15:0]       sync1;
    logic [15:0]       sync2;
    logic              rdy;
  } fses_state_t;

  fses_state_t s_q, s_d;

  // Unlock address for slot 1 or 2 in the current width
  function automatic logic [18:0] unl(input logic second, input logic bm);
    if (bm)
      unl = second ? UNLOCK2_BYTE : UNLOCK1_BYTE;
    else
      unl = second ? UNLOCK2_WORD : UNLOCK1_WORD;
  endfunction : unl

  // Number of bus writes for each command but read, which makes none
  function automatic logic [2:0] op_len(input fses_op_t op);
    case (op)
      FSES_OP_SECTOR, FSES_OP_CHIP:               op_len = 3'h6;
      FSES_OP_PROGRAM:                            op_len = 3'h4;
      FSES_OP_IDENT, FSES_OP_FAST_IN:             op_len = 3'h3;
      FSES_OP_FAST_PGM, FSES_OP_FAST_OUT:         op_len = 3'h2;
      default:                                    op_len = 3'h1;
    endcase
  endfunction : op_len

  // Address and data of write slot i of a command
  function automatic logic [34:0] slot(input fses_req_t r, input logic [2:0] i,
                                       input logic bm);
    logic [18:0] a;
    logic [15:0] d;
    a = 19'h00000;
    d = 16'h0000;
    case (r.op)
      FSES_OP_SECTOR, FSES_OP_CHIP, FSES_OP_PROGRAM, FSES_OP_IDENT,
      FSES_OP_FAST_IN: begin
        case (i)
          3'h0, 3'h3: begin a = unl(1'b0, bm); d = {8'h00, CMD_UNLOCK1}; end
          3'h1, 3'h4: begin a = unl(1'b1, bm); d = {8'h00, CMD_UNLOCK2}; end
          3'h2: begin
            a = unl(1'b0, bm);
            case (r.op)
              FSES_OP_PROGRAM: d = {8'h00, CMD_PROGRAM};
              FSES_OP_IDENT:   d = {8'h00, CMD_IDENT};
              FSES_OP_FAST_IN: d = {8'h00, CMD_FAST};
              default:         d = {8'h00, CMD_SETUP};
            endcase
          end
          default: begin
            if (r.op == FSES_OP_PROGRAM) begin
              a = r.addr;
              d = r.data;
            end else if (r.op == FSES_OP_CHIP) begin
              a = unl(1'b0, bm);
              d = {8'h00, CMD_CHIP};
            end else begin
              a = r.addr;
              d = {8'h00, CMD_SECTOR};
            end
          end
        endcase
        if (r.op == FSES_OP_PROGRAM && i == 3'h3) begin
          a = r.addr;
          d = r.data;
        end
      end
      FSES_OP_FAST_PGM: begin
        a = (i == 3'h0) ? 19'h00000 : r.addr;
        d = (i == 3'h0) ? {8'h00, CMD_PROGRAM} : r.data;
      end
      FSES_OP_FAST_OUT:
        d = (i == 3'h0) ? {8'h00, CMD_IDENT} : {8'h00, CMD_FAST_EXIT};
      FSES_OP_ADD_SEC: begin
        a = r.addr;
        d = {8'h00, CMD_SECTOR};
      end
      FSES_OP_SUSPEND: d = {8'h00, CMD_SUSPEND};
      FSES_OP_RESUME:  d = {8'h00, CMD_RESUME};
      default:         d = {8'h00, CMD_RESET};
    endcase
    slot = {a, d};
  endfunction : slot

  always_comb begin
    logic [34:0] sl;
    s_d = s_q;
    sl = slot(s_q.cur, s_q.idx, s_q.bmode);
    s_d.rsp_v = 1'b0;
    s_d.sync1 = dq_i;
    s_d.sync2 = s_q.sync1;
    if (s_q.gap != 16'h0000)
      s_d.gap = s_q.gap - 16'h0001;
    else
      s_d.win = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (req_valid) begin
          s_d.cur = req;
          s_d.bmode = byte_mode;
          s_d.idx = 3'h0;
          s_d.ph = 4'h0;
          s_d.rd = (req.op == FSES_OP_READ);
          s_d.len = op_len(req.op);
          // Added sector after the host-side spacing budget is flagged
          if (req.op == FSES_OP_ADD_SEC)
            s_d.late = !s_q.win;
          s_d.st = ST_LOAD;
        end
      end
      ST_LOAD: begin
        s_d.pins.ce_n = 1'b0;
        s_d.pins.addr = s_q.rd ? s_q.cur.addr : sl[34:16];
        s_d.pins.dq_o = sl[15:0];
        s_d.pins.dq_oe_n = s_q.rd;
        s_d.ph = 4'h0;
        s_d.st = s_q.rd ? ST_RLOW : ST_LOW;
        if (s_q.rd)
          s_d.pins.oe_n = 1'b0;
        else
          s_d.pins.we_n = 1'b0;
      end
      ST_LOW: begin
        s_d.ph = s_q.ph + 4'h1;
        if (s_q.ph == STROBE_LO) begin
          s_d.pins.we_n = 1'b1;
          s_d.ph = 4'h0;
          s_d.st = ST_HIGH;
        end
      end
      ST_RLOW: begin
        s_d.ph = s_q.ph + 4'h1;
        // Two extra clocks cover the dq synchroniser
        if (s_q.ph == STROBE_LO + SYNC_LAT) begin
          s_d.rsp_d = s_q.sync2;
          s_d.pins.oe_n = 1'b1;
          s_d.pins.ce_n = 1'b1;
          s_d.ph = 4'h0;
          s_d.st = ST_DONE;
        end
      end
      ST_HIGH: begin
        s_d.pins.ce_n = 1'b1;
        s_d.pins.dq_oe_n = 1'b1;
        s_d.ph = s_q.ph + 4'h1;
        if (s_q.ph == STROBE_HI) begin
          s_d.idx = s_q.idx + 3'h1;
          s_d.st = (s_q.idx + 3'h1 == s_q.len) ? ST_DONE : ST_LOAD;
          // Window runs from the end of the strobe-high phase of the final sector write
          if ((s_q.cur.op == FSES_OP_SECTOR || s_q.cur.op == FSES_OP_ADD_SEC)
              && s_q.idx + 3'h1 == s_q.len) begin
            s_d.win = 1'b1;
            s_d.gap = SPACING[15:0];
          end
          if (s_q.cur.op == FSES_OP_SUSPEND || s_q.cur.op == FSES_OP_RESET)
            s_d.win = 1'b0;
        end
      end
      ST_DONE: begin
        s_d.rsp_v = 1'b1;
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Ready comes from a flop so the user port sees no decode glitch
    s_d.rdy = (s_d.st == ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.rdy <= 1'b1;
      s_q.pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 19'h00000,
                    dq_o: 16'h0000, dq_oe_n: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // Ready only in idle: one command at a time
  assign req_ready = s_q.rdy;
  assign rsp_valid = s_q.rsp_v;
  assign rsp_data = s_q.rsp_d;
  assign window_open = s_q.win;
  assign spacing_late = s_q.late;
  assign pins = s_q.pins;

endmodule : fses_ctrl
`default_nettype wire

/* fses_pkg.sv */
package fses_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned DATA_W = 16;

  // Unlock and command addresses, word and byte width
  localparam logic [18:0] UNLOCK1_WORD = 19'h00555;
  localparam logic [18:0] UNLOCK2_WORD = 19'h002aa;
  localparam logic [18:0] UNLOCK1_BYTE = 19'h00aaa;
  localparam logic [18:0] UNLOCK2_BYTE = 19'h00555;

  // Command data codes
  localparam logic [7:0] CMD_UNLOCK1   = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2   = 8'h55;
  localparam logic [7:0] CMD_SETUP     = 8'h80;
  localparam logic [7:0] CMD_SECTOR    = 8'h30;
  localparam logic [7:0] CMD_CHIP      = 8'h10;
  localparam logic [7:0] CMD_SUSPEND   = 8'hb0;
  localparam logic [7:0] CMD_RESUME    = 8'h30;
  localparam logic [7:0] CMD_PROGRAM   = 8'ha0;
  localparam logic [7:0] CMD_FAST      = 8'h20;
  localparam logic [7:0] CMD_IDENT     = 8'h90;
  localparam logic [7:0] CMD_FAST_EXIT = 8'h00;
  localparam logic [7:0] CMD_RESET     = 8'hf0;

  // Status bit positions
  localparam int unsigned BIT_POLL   = 7;
  localparam int unsigned BIT_TOGGLE = 6;
  localparam int unsigned BIT_TIMER  = 3;
  localparam int unsigned BIT_SUSTOG = 2;

  // Timing at 25 MHz
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned WINDOW_US    = 50;
  localparam int unsigned SUSPEND_US   = 20;
  // Host spacing must stay under the window: leave margin of 10 us
  localparam int unsigned SPACING_US   = 40;
  localparam int unsigned SPACING_CYC  = SPACING_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SUSPEND_CYC  = SUSPEND_US * (CLK_HZ / 1_000_000);
  // Last phase count of each bus cycle phase (strobe low, strobe high); strobe low lasts 4 clocks
  localparam logic [3:0]  STROBE_LO    = 4'h3;
  localparam logic [3:0]  STROBE_HI    = 4'h3;
  // Clocks that read data spends in the input synchroniser
  localparam logic [3:0]  SYNC_LAT     = 4'h2;

  // User commands
  typedef enum logic [3:0] {
    FSES_OP_READ     = 4'h0,
    FSES_OP_RESET    = 4'h1,
    FSES_OP_PROGRAM  = 4'h2,
    FSES_OP_SECTOR   = 4'h3,
    FSES_OP_CHIP     = 4'h4,
    FSES_OP_SUSPEND  = 4'h5,
    FSES_OP_RESUME   = 4'h6,
    FSES_OP_FAST_IN  = 4'h7,
    FSES_OP_FAST_PGM = 4'h8,
    FSES_OP_FAST_OUT = 4'h9,
    FSES_OP_IDENT    = 4'ha,
    FSES_OP_ADD_SEC  = 4'hb
  } fses_op_t;

  typedef struct packed {
    fses_op_t          op;
    logic [18:0]       addr;
    logic [15:0]       data;
  } fses_req_t;

  // Flash pins the controller drives
  typedef struct packed {
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic [18:0]       addr;
    logic [15:0]       dq_o;
    logic              dq_oe_n;
  } fses_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_LOW   = 3'b011,
    ST_HIGH  = 3'b010,
    ST_RLOW  = 3'b110,
    ST_DONE  = 3'b111
  } fses_st_t;

endpackage : fses_pkg

/* fses_ctrl_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module fses_ctrl_chk
  import fses_pkg::*;
#(
  parameter int unsigned SPACING = SPACING_CYC
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // Watched ports
  input wire logic              req_valid,
  input wire fses_req_t         req,
  input wire logic              byte_mode,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic [DATA_W-1:0] rsp_data,
  input wire logic              window_open,
  input wire logic              spacing_late,
  input wire fses_pins_t        pins,
  input wire logic [DATA_W-1:0] dq_i
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_strobe; $fell(pins.we_n); endsequence
  a_busy_after_take: assert property (s_take |=> !req_ready)
    else $error("ready stayed high after a take");
  a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer pulse longer than one cycle");
  a_ready_after_rsp: assert property (rsp_valid |-> req_ready)
    else $error("not ready after the answer");
  a_strobe_in_ce: assert property (!pins.we_n |-> !pins.ce_n)
    else $error("write strobe outside chip enable");
  a_read_no_drive: assert property (!pins.oe_n |-> pins.dq_oe_n)
    else $error("data driven during a read");
  a_strobes_apart: assert property (!(!pins.we_n && !pins.oe_n))
    else $error("read and write strobes together");
  a_strobe_low_len: assert property (s_strobe |-> (!pins.we_n)[*4])
    else $error("write strobe too short");
  a_addr_held: assert property (!pins.we_n && !$past(pins.we_n)
    |-> $stable(pins.addr) && $stable(pins.dq_o))
    else $error("address or data moved under the strobe");
  a_window_then_rsp: assert property ($rose(window_open)
    |-> ##[1:12] rsp_valid)
    else $error("window opened away from the final write");
endmodule : fses_ctrl_chk
bind fses_ctrl fses_ctrl_chk #(.SPACING(SPACING)) fses_ctrl_chk_inst (
  .clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
  .byte_mode(byte_mode), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .window_open(window_open),
  .spacing_late(spacing_late), .pins(pins), .dq_i(dq_i));
`default_nettype wire

/* fses_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fses_flash_model
  import fses_pkg::*;
#(
  parameter int unsigned ERASE_NS = 4000
) (
  // Flash pins
  input  wire fses_pins_t   pins,
  output logic [DATA_W-1:0] dq_i
);
  logic [34:0] wlog [$];
  logic [15:0] last = 16'h0000;
  logic        tog = 1'b0;
  logic        sus = 1'b0;
  logic        armed = 1'b0;
  time         t0 = 0;
  // Sectors queued for erase, one bit per sector
  logic [127:0] sel = '0;
  // Only the aa, 80 and 55 writes of the unlock run are matched exactly; a broken one falls back to reading
  function automatic logic hit(int k, logic [18:0] a, logic [7:0] d);
    return wlog.size() >= k && wlog[wlog.size()-k] === {a, 8'h00, d};
  endfunction : hit
  // Suspension outlives any write but resume, identification included
  function automatic logic busy(time lim);
    return armed && !sus && ($time - t0 < lim);
  endfunction : busy
  // Real flash has no clock: writes land on the strobe's rising edge
  always @(posedge pins.we_n) if (pins.ce_n === 1'b0) begin
    wlog.push_back({pins.addr, pins.dq_o});
    if (pins.dq_o[7:0] == CMD_SUSPEND && busy(50000 + ERASE_NS))
      sus = 1'b1;
    else if (pins.dq_o[7:0] == CMD_RESUME && sus) begin
      sus = 1'b0;
      t0 = $time - 50000;
    end else if (pins.dq_o[7:0] == CMD_SECTOR && (busy(50000) ||
      hit(2, UNLOCK2_WORD, 8'h55) && hit(4, UNLOCK1_WORD, 8'h80) &&
      hit(6, UNLOCK1_WORD, 8'haa))) begin
      if (!busy(50000))
        sel = '0;
      sel[pins.addr[18:12]] = 1'b1;
      armed = 1'b1;
      t0 = $time;
    end else if (busy(50000))
      armed = 1'b0;
  end
  always @(negedge pins.oe_n) begin
    tog = tog ^ busy(50000 + ERASE_NS);
    last = (busy(50000 + ERASE_NS) || (sus && sel[pins.addr[18:12]])) ?
      {8'h00, sus, tog, 2'b00, !busy(50000), 3'b000} :
      ~pins.addr[15:0];
  end
  // Released bus shows the inverse so stale data cannot pass
  assign dq_i = pins.oe_n ? ~last : last;
endmodule : fses_flash_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import fses_pkg::*;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              req_valid = 1'b0;
  fses_req_t         req = '0;
  logic              byte_mode = 1'b0;
  logic              req_ready, rsp_valid, window_open, spacing_late;
  logic [DATA_W-1:0] rsp_data, dq_i, r1;
  fses_pins_t        pins;
  int                n_fail = 0;
  int                n_checks = 0;
  int                cyc = 0;
  fses_op_t    ops [7] = '{FSES_OP_IDENT, FSES_OP_RESET, FSES_OP_CHIP,
    FSES_OP_FAST_IN, FSES_OP_FAST_PGM, FSES_OP_FAST_OUT, FSES_OP_PROGRAM};
  int          nw [7] = '{3, 1, 6, 3, 2, 2, 4};
  logic [7:0]  lw [7] = '{8'h90, 8'hf0, 8'h10, 8'h20, 8'h5a, 8'h00, 8'h5a};
  logic [7:0]  seq [6] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55, 8'h30};
  fses_ctrl #(.SPACING(20)) fses_ctrl_inst (.clk(clk), .nrst(nrst),
    .req_valid(req_valid), .req(req), .byte_mode(byte_mode),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .window_open(window_open), .spacing_late(spacing_late), .pins(pins),
    .dq_i(dq_i));
  fses_flash_model fses_flash_model_inst (.pins(pins), .dq_i(dq_i));
  always #20 clk = ~clk;
  function automatic logic [34:0] wl(int k);
    return fses_flash_model_inst.wlog[fses_flash_model_inst.wlog.size()-k];
  endfunction : wl
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic do_req(input fses_op_t op, input logic [18:0] a,
                        input logic [15:0] d, input int n);
    int k;
    int s;
    s = fses_flash_model_inst.wlog.size();
    k = 0;
    while (req_ready !== 1'b1 && k < 400) begin @(negedge clk); k++; end
    req = '{op: op, addr: a, data: d};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && k < 400) begin @(negedge clk); k++; end
    if (k >= 400)
      n_fail++;
    check(19'(fses_flash_model_inst.wlog.size() - s), 19'(n));
  endtask : do_req
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin n_fail++; end_of_test(); end
  end
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    check(19'(req_ready), 19'h1);
    do_req(FSES_OP_SECTOR, 19'h30000, 16'h0000, 6);
    for (int i = 0; i < 6; i++) check(19'(wl(6-i) & 8'hff), 19'(seq[i]));
    check(19'(wl(6) >> 16), UNLOCK1_WORD);
    check(19'(wl(5) >> 16), UNLOCK2_WORD);
    check(19'(wl(1) >> 16), 19'h30000);
    check(19'(window_open), 19'h1);
    do_req(FSES_OP_ADD_SEC, 19'h40000, 16'h0000, 1);
    check(19'(spacing_late), 19'h0);
    do_req(FSES_OP_READ, 19'h30000, 16'h0000, 0);
    r1 = rsp_data;
    do_req(FSES_OP_READ, 19'h30000, 16'h0000, 0);
    check(19'(rsp_data[7:6]), 19'({1'b0, ~r1[6]}));
    check(19'(rsp_data[3]), 19'h0);
    repeat (30) @(negedge clk);
    do_req(FSES_OP_ADD_SEC, 19'h50000, 16'h0000, 1);
    check(19'(spacing_late), 19'h1);
    do_req(FSES_OP_SUSPEND, 19'h00000, 16'h0000, 1);
    check(19'(window_open), 19'h0);
    check(19'(wl(1) & 8'hff), 19'(CMD_SUSPEND));
    do_req(FSES_OP_READ, 19'h30000, 16'h0000, 0);
    check(19'(rsp_data[7]), 19'h1);
    do_req(FSES_OP_READ, 19'h00123, 16'h0000, 0);
    check(19'(rsp_data), 19'h0fedc);
    do_req(FSES_OP_PROGRAM, 19'h00200, 16'h005a, 4);
    do_req(FSES_OP_READ, 19'h00123, 16'h0000, 0);
    check(19'(rsp_data), 19'h0fedc);
    do_req(FSES_OP_IDENT, 19'h00000, 16'h0000, 3);
    do_req(FSES_OP_RESET, 19'h00000, 16'h0000, 1);
    do_req(FSES_OP_READ, 19'h30000, 16'h0000, 0);
    check(19'(rsp_data[7]), 19'h1);
    do_req(FSES_OP_RESUME, 19'h00000, 16'h0000, 1);
    check(19'(wl(1) & 8'hff), 19'(CMD_RESUME));
    do_req(FSES_OP_READ, 19'h30000, 16'h0000, 0);
    check(19'(rsp_data[7]), 19'h0);
    check(19'(rsp_data[3]), 19'h1);
    repeat (200) @(negedge clk);
    do_req(FSES_OP_READ, 19'h00123, 16'h0000, 0);
    check(19'(rsp_data), 19'h0fedc);
    for (int i = 0; i < 7; i++) begin
      byte_mode = (i == 6);
      do_req(ops[i], 19'h00200, 16'h005a, nw[i]);
      check(19'(wl(1) & 8'hff), 19'(lw[i]));
    end
    check(19'(wl(4) >> 16), UNLOCK1_BYTE);
    check(19'(wl(2) & 8'hff), 19'(CMD_PROGRAM));
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
